// *** fpcs_map.svh ***
`ifndef FPCS_MAP_SVH
`define FPCS_MAP_SVH
// register byte offsets on the wishbone slave
`define FPCS_CTRL_OFS 4'h0
`define FPCS_ADDR_OFS 4'h4
// field positions in the context control word
`define FPCS_BIT_LAZY 0
`define FPCS_BIT_USER 1
`define FPCS_BIT_OWNER 2
`define FPCS_BIT_THREAD 3
`define FPCS_BIT_HARD_FAULT_READY 4
`define FPCS_BIT_MEMORY_FAULT_READY 5
`define FPCS_BIT_BUS_FAULT_READY 6
// reset values
`define FPCS_CTRL_RST 7'h00
`define FPCS_ADDR_RST 29'h0000_0000
// context address alignment
`define FPCS_ADDR_LSB 3
`endif

// *** fpcs_pkg.sv ***
package fpcs_pkg;
  // security state selecting a banked copy
  typedef enum logic {
    FPCS_NS = 1'b0,
    FPCS_S = 1'b1
  } fpcs_sec_t;
  // wishbone slave states
  typedef enum logic [1:0] {
    FPCS_IDLE = 2'b00,
    FPCS_ACK = 2'b01,
    FPCS_WAIT = 2'b10
  } fpcs_wb_t;
endpackage : fpcs_pkg

// *** fpcs_wb_if.sv ***
`timescale 1ns/1ps
interface fpcs_wb_if;
  logic req;
  logic we;
  logic [3:0] adr;
  logic [31:0] wdat;
  logic [3:0] sel;
  logic [31:0] rdat;
  logic ack;
  modport slave (input req, input we, input adr, input wdat, input sel,
    output rdat, output ack);
  modport master (output req, output we, output adr, output wdat,
    output sel, input rdat, input ack);
endinterface : fpcs_wb_if

// *** fpcs_wb_slave.sv ***
`timescale 1ns/1ps
module fpcs_wb_slave (
  input wire logic clk_sys,
  input wire logic rst,
  fpcs_wb_if.slave bus,
  input wire logic [31:0] rd_data,
  output logic wr_fire
);
  fpcs_pkg::fpcs_wb_t st_r;
  fpcs_pkg::fpcs_wb_t st_nxt;
  logic [31:0] rdat_r;

  // one-wait answer, then a mandatory idle cycle
  always_comb begin
    unique case (st_r)
      fpcs_pkg::FPCS_IDLE: st_nxt = bus.req ? fpcs_pkg::FPCS_ACK
                                            : fpcs_pkg::FPCS_IDLE;
      fpcs_pkg::FPCS_ACK: st_nxt = fpcs_pkg::FPCS_WAIT;
      fpcs_pkg::FPCS_WAIT: st_nxt = fpcs_pkg::FPCS_IDLE;
      default: st_nxt = fpcs_pkg::FPCS_IDLE;
    endcase
  end

  // state and read data capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= fpcs_pkg::FPCS_IDLE;
      rdat_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      if (st_r == fpcs_pkg::FPCS_IDLE && bus.req) begin
        rdat_r <= rd_data;
      end
    end
  end

  assign bus.ack = (st_r == fpcs_pkg::FPCS_ACK);
  assign bus.rdat = rdat_r;
  assign wr_fire = bus.ack & bus.we; // write lands at the ack edge
endmodule : fpcs_wb_slave

// *** fpcs_regs.sv ***
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "fpcs_map.svh"
// Notes on behaviour
// [RULE1] Bit 6 captures bus fault pend ability at frame allocation, shared.
// [RULE2] Non-secure access sees bits 6, 4 as zero, no write, if not routed.
// [RULE3] Bit 5 captures memory fault pend ability, one copy per state.
// [RULE4] Bit 4 captures hard fault pend ability at allocation, shared.
// [RULE5] Bit 3 records thread (1) or handler (0) mode, banked, info only.
// [RULE6] Bit 2 holds the context owner, zero and unwritable to non-secure.
// [RULE7] Owner updates on lazy preservation start and on each fp instruction.
// [RULE8] Bit 1 records unprivileged (1) or privileged (0), banked.
// [RULE9] Bit 0 shows lazy preservation pending, one copy per state.
// [RULE10] Address bits 31 to 3 point at the fp register area of the frame.
// [RULE11] Address bits 2 to 0 read zero, keeping eight-byte alignment.
// [RULE12] Each security state has its own address copy, chosen by the core.
// [RULE13] All captured bits and the address load in the allocation cycle.
module fpcs_regs (
  input wire logic clk_sys,
  input wire logic rst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // state of the software access
  input wire logic acc_secure,
  input wire logic faults_to_nonsecure,
  // processor state
  input wire logic cur_secure,
  // frame allocation from exception entry
  input wire logic frame_alloc,
  input wire logic bus_fault_able,
  input wire logic memory_fault_able,
  input wire logic hard_fault_able,
  input wire logic thread_mode,
  input wire logic unprivileged,
  input wire logic [31:0] frame_fp_addr,
  // lazy state events
  input wire logic lazy_activate,
  input wire logic lazy_done,
  input wire logic fp_instr,
  // status towards the core
  output logic lazy_save_pending_s,
  output logic lazy_save_pending_ns,
  output logic fp_owner_secure,
  output logic [31:0] fp_context_address
);
  fpcs_wb_if bus ();
  logic wr_fire;
  logic [31:0] rd_data;

  // shared and banked stored fields
  logic bus_fault_ready_r;
  logic hard_fault_ready_r;
  logic owner_r;
  logic [1:0] memory_fault_ready_r;
  logic [1:0] thread_r;
  logic [1:0] user_r;
  logic [1:0] lazy_save_pending_r;
  logic [28:0] addr_r [2];

  // write-enable byte lane decode, used for the control register only
  function automatic logic lane0(input logic [3:0] sel);
    lane0 = sel[0];
  endfunction : lane0

  // bus wiring into the slave carrier
  assign bus.req = wb_cyc_i & wb_stb_i;
  assign bus.we = wb_we_i;
  assign bus.adr = wb_adr_i;
  assign bus.wdat = wb_dat_i;
  assign bus.sel = wb_sel_i;
  assign wb_dat_o = bus.rdat;
  assign wb_ack_o = bus.ack;

  fpcs_wb_slave u_slave (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(bus),
    .rd_data(rd_data),
    .wr_fire(wr_fire)
  );

  // access decode and banked selection
  wire logic bank = acc_secure;
  wire logic fault_vis = acc_secure | faults_to_nonsecure; // RULE2
  wire logic hit_ctrl = (bus.adr == `FPCS_CTRL_OFS);
  wire logic hit_addr = (bus.adr == `FPCS_ADDR_OFS);
  wire logic wr_ctrl = wr_fire & hit_ctrl & lane0(bus.sel);
  wire logic [3:0] addr_lane = bus.sel & {4{wr_fire & hit_addr}};
  wire logic [31:0] wr_word = bus.wdat;
  wire logic alloc_bank = cur_secure;
  wire logic [31:0] addr_view = {addr_r[bank], 3'b000}; // RULE11

  // read view of the control word
  wire logic [6:0] ctrl_view = {
    bus_fault_ready_r & fault_vis,        // RULE2
    memory_fault_ready_r[bank],
    hard_fault_ready_r & fault_vis,       // RULE2
    thread_r[bank],
    owner_r & acc_secure,                 // RULE6
    user_r[bank],
    lazy_save_pending_r[bank]
  };
  assign rd_data = hit_ctrl ? {25'h0, ctrl_view} :
                   hit_addr ? addr_view : 32'h0000_0000;

  // shared fault-ready bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_fault_ready_r <= 1'b0;
      hard_fault_ready_r <= 1'b0;
    end else if (frame_alloc) begin
      bus_fault_ready_r <= bus_fault_able;   // RULE1 RULE13
      hard_fault_ready_r <= hard_fault_able; // RULE4 RULE13
    end else if (wr_ctrl && fault_vis) begin // RULE2
      bus_fault_ready_r <= wr_word[`FPCS_BIT_BUS_FAULT_READY];
      hard_fault_ready_r <= wr_word[`FPCS_BIT_HARD_FAULT_READY];
    end
  end

  // context owner: hardware update wins over software write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      owner_r <= 1'b0;
    end else if (lazy_activate || fp_instr) begin
      owner_r <= cur_secure; // RULE7
    end else if (wr_ctrl && acc_secure) begin
      owner_r <= wr_word[`FPCS_BIT_OWNER]; // RULE6
    end
  end

  // banked control fields, one copy per security state
  for (genvar b = 0; b < 2; b++) begin : g_bank
    localparam logic bank_id = 1'(b);
    wire logic alloc_here = frame_alloc & (alloc_bank == bank_id);
    wire logic wr_here = wr_ctrl & (bank == bank_id);
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        memory_fault_ready_r[b] <= 1'b0;
        thread_r[b] <= 1'b0;
        user_r[b] <= 1'b0;
      end else if (alloc_here) begin
        memory_fault_ready_r[b] <= memory_fault_able; // RULE3 RULE13
        thread_r[b] <= thread_mode;                   // RULE5
        user_r[b] <= unprivileged;                    // RULE8
      end else if (wr_here) begin
        memory_fault_ready_r[b] <= wr_word[`FPCS_BIT_MEMORY_FAULT_READY];
        thread_r[b] <= wr_word[`FPCS_BIT_THREAD];
        user_r[b] <= wr_word[`FPCS_BIT_USER];
      end
    end

    // lazy flag: set wins over clear and over software
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        lazy_save_pending_r[b] <= 1'b0;
      end else if (lazy_activate && alloc_bank == bank_id) begin
        lazy_save_pending_r[b] <= 1'b1; // RULE9
      end else if (lazy_done && alloc_bank == bank_id) begin
        lazy_save_pending_r[b] <= 1'b0; // RULE9
      end else if (wr_here) begin
        lazy_save_pending_r[b] <= wr_word[`FPCS_BIT_LAZY];
      end
    end

    // banked context address, byte lanes honoured
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        addr_r[b] <= `FPCS_ADDR_RST;
      end else if (alloc_here) begin
        addr_r[b] <= frame_fp_addr[31:`FPCS_ADDR_LSB]; // RULE10 RULE12
      end else if (bank == bank_id) begin
        if (addr_lane[0]) addr_r[b][4:0] <= wr_word[7:3];
        if (addr_lane[1]) addr_r[b][12:5] <= wr_word[15:8];
        if (addr_lane[2]) addr_r[b][20:13] <= wr_word[23:16];
        if (addr_lane[3]) addr_r[b][28:21] <= wr_word[31:24];
      end
    end
  end

  // status outputs
  assign lazy_save_pending_s = lazy_save_pending_r[1];
  assign lazy_save_pending_ns = lazy_save_pending_r[0];
  assign fp_owner_secure = owner_r;
  assign fp_context_address = {addr_r[cur_secure], 3'b000}; // RULE12

  // checks
  property p_bf_capture;
    @(posedge clk_sys) disable iff (rst)
    frame_alloc |=> bus_fault_ready_r == $past(bus_fault_able);
  endproperty
  a_bf_capture: assert property (p_bf_capture) // RULE1
    else $error("bus fault ready not captured");

  property p_raz_ns;
    @(posedge clk_sys) disable iff (rst)
    (!acc_secure && !faults_to_nonsecure && hit_ctrl) |->
      (rd_data[`FPCS_BIT_BUS_FAULT_READY] == 1'b0 && rd_data[`FPCS_BIT_HARD_FAULT_READY] == 1'b0);
  endproperty
  a_raz_ns: assert property (p_raz_ns) // RULE2
    else $error("fault ready bits visible to non-secure");

  property p_mm_bank;
    @(posedge clk_sys) disable iff (rst)
    frame_alloc |=>
      memory_fault_ready_r[$past(cur_secure)] == $past(memory_fault_able);
  endproperty
  a_mm_bank: assert property (p_mm_bank) // RULE3
    else $error("memory fault ready not banked");

  property p_hf_capture;
    @(posedge clk_sys) disable iff (rst)
    frame_alloc |=> hard_fault_ready_r == $past(hard_fault_able);
  endproperty
  a_hf_capture: assert property (p_hf_capture) // RULE4
    else $error("hard fault ready not captured");

  property p_owner_hide;
    @(posedge clk_sys) disable iff (rst)
    (!acc_secure && hit_ctrl) |-> rd_data[`FPCS_BIT_OWNER] == 1'b0;
  endproperty
  a_owner_hide: assert property (p_owner_hide) // RULE6
    else $error("owner bit visible to non-secure");

  property p_owner_upd;
    @(posedge clk_sys) disable iff (rst)
    (lazy_activate || fp_instr) |=> owner_r == $past(cur_secure);
  endproperty
  a_owner_upd: assert property (p_owner_upd) // RULE7
    else $error("owner bit not updated");

  property p_lazy_set;
    @(posedge clk_sys) disable iff (rst)
    lazy_activate |=> lazy_save_pending_r[$past(cur_secure)];
  endproperty
  a_lazy_set: assert property (p_lazy_set) // RULE9
    else $error("lazy pending not set");

  property p_addr_align;
    @(posedge clk_sys) disable iff (rst)
    hit_addr |-> rd_data[2:0] == 3'b000;
  endproperty
  a_addr_align: assert property (p_addr_align) // RULE11
    else $error("address low bits not zero");

  property p_addr_cap;
    @(posedge clk_sys) disable iff (rst)
    (frame_alloc && cur_secure) ##1 cur_secure |->
      fp_context_address == ($past(frame_fp_addr) & 32'hffff_fff8);
  endproperty
  a_addr_cap: assert property (p_addr_cap) // RULE10 RULE12 RULE13
    else $error("context address not captured");
  property p_addr_ns;
    @(posedge clk_sys) disable iff (rst)
    (frame_alloc && !cur_secure) |=>
      {addr_r[0], 3'b000} == ($past(frame_fp_addr) & 32'hffff_fff8);
  endproperty
  a_addr_ns: assert property (p_addr_ns) // RULE10 RULE12
    else $error("non-secure context address not captured");
  property p_thread_cap;
    @(posedge clk_sys) disable iff (rst)
    frame_alloc |=> thread_r[$past(cur_secure)] == $past(thread_mode);
  endproperty
  a_thread_cap: assert property (p_thread_cap) // RULE5
    else $error("thread mode not captured");
  property p_user_cap;
    @(posedge clk_sys) disable iff (rst)
    frame_alloc |=> user_r[$past(cur_secure)] == $past(unprivileged);
  endproperty
  a_user_cap: assert property (p_user_cap) // RULE8
    else $error("privilege level not captured");
  property p_mm_other;
    @(posedge clk_sys) disable iff (rst)
    (frame_alloc && cur_secure && !(wr_ctrl && !acc_secure)) |=>
      $stable(memory_fault_ready_r[0]);
  endproperty
  a_mm_other: assert property (p_mm_other) // RULE3
    else $error("secure capture disturbed non-secure copy");

  // software write protection, visibility, and lazy flag clear and hold
  property p_bf_wi;
    @(posedge clk_sys) disable iff (rst)
    (wr_ctrl && !fault_vis && !frame_alloc) |=>
      $stable(bus_fault_ready_r);
  endproperty
  a_bf_wi: assert property (p_bf_wi) // RULE2
    else $error("bus fault ready written from non-secure");
  property p_hf_wi;
    @(posedge clk_sys) disable iff (rst)
    (wr_ctrl && !fault_vis && !frame_alloc) |=>
      $stable(hard_fault_ready_r);
  endproperty
  a_hf_wi: assert property (p_hf_wi) // RULE2
    else $error("hard fault ready written from non-secure");
  property p_owner_wi;
    @(posedge clk_sys) disable iff (rst)
    (wr_ctrl && !acc_secure && !lazy_activate && !fp_instr) |=>
      $stable(owner_r);
  endproperty
  a_owner_wi: assert property (p_owner_wi) // RULE6
    else $error("owner bit written from non-secure");
  property p_fault_vis;
    @(posedge clk_sys) disable iff (rst)
    (!acc_secure && faults_to_nonsecure && hit_ctrl) |->
      (rd_data[`FPCS_BIT_BUS_FAULT_READY] == bus_fault_ready_r &&
       rd_data[`FPCS_BIT_HARD_FAULT_READY] == hard_fault_ready_r);
  endproperty
  a_fault_vis: assert property (p_fault_vis) // RULE2
    else $error("routed fault ready bits hidden");
  property p_lazy_clr;
    @(posedge clk_sys) disable iff (rst)
    (lazy_done && !lazy_activate) |=>
      !lazy_save_pending_r[$past(cur_secure)];
  endproperty
  a_lazy_clr: assert property (p_lazy_clr) // RULE9
    else $error("lazy pending not cleared");
  property p_lazy_hold;
    @(posedge clk_sys) disable iff (rst)
    (!lazy_activate && !lazy_done && !wr_ctrl) |=>
      $stable(lazy_save_pending_r);
  endproperty
  a_lazy_hold: assert property (p_lazy_hold) // RULE9
    else $error("lazy pending changed without cause");

  // bus handshake and reset state
  property p_ack_next;
    @(posedge clk_sys) disable iff (rst)
    $rose(bus.req) |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack not given one cycle after request");
  property p_ack_pulse;
    @(posedge clk_sys) disable iff (rst)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_rdat_hold;
    @(posedge clk_sys) disable iff (rst)
    !bus.req |=> $stable(wb_dat_o);
  endproperty
  a_rdat_hold: assert property (p_rdat_hold)
    else $error("read data changed without request");
  property p_reset_state;
    @(posedge clk_sys)
    rst |=> (!wb_ack_o && wb_dat_o == 32'h0000_0000 &&
      !fp_owner_secure && !lazy_save_pending_s && !lazy_save_pending_ns);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not cleared by reset");

  c_alloc: cover property (@(posedge clk_sys) disable iff (rst)
    frame_alloc ##2 frame_alloc);
  c_ns_write: cover property (@(posedge clk_sys) disable iff (rst)
    wr_ctrl && !acc_secure && !faults_to_nonsecure);
  c_lazy: cover property (@(posedge clk_sys) disable iff (rst)
    lazy_activate ##[1:20] lazy_done);
  c_ns_read: cover property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o && !acc_secure && !wb_we_i);
endmodule : fpcs_regs

// *** fpcs_core_model.sv ***
`timescale 1ns/1ps
module fpcs_core_model (
  input wire logic clk_sys,
  output logic cur_secure,
  output logic frame_alloc,
  output logic bus_fault_able,
  output logic memory_fault_able,
  output logic hard_fault_able,
  output logic thread_mode,
  output logic unprivileged,
  output logic [31:0] frame_fp_addr,
  output logic lazy_activate,
  output logic lazy_done,
  output logic fp_instr
);
  // quiet core at start
  initial begin
    cur_secure = 1'b1;
    {frame_alloc, lazy_activate, lazy_done, fp_instr} = 4'h0;
    {bus_fault_able, memory_fault_able, hard_fault_able} = 3'h0;
    {thread_mode, unprivileged} = 2'h0;
    frame_fp_addr = 32'h0;
  end

  // frame allocation pulse; fields scrambled once the capture edge passed
  task automatic alloc(input logic sec, input logic [4:0] flg,
    input logic [31:0] adr);
    @(posedge clk_sys);
    cur_secure <= sec;
    frame_alloc <= 1'b1;
    {bus_fault_able, memory_fault_able, hard_fault_able, thread_mode,
      unprivileged} <= flg;
    frame_fp_addr <= adr;
    @(posedge clk_sys);
    frame_alloc <= 1'b0;
    {bus_fault_able, memory_fault_able, hard_fault_able, thread_mode,
      unprivileged} <= ~flg;
    frame_fp_addr <= ~adr;
  endtask : alloc

  // one-cycle event: 0 lazy start, 1 lazy done, 2 fp instruction
  task automatic event_pulse(input logic sec, input logic [1:0] kind);
    @(posedge clk_sys);
    cur_secure <= sec;
    {lazy_activate, lazy_done, fp_instr} <= 3'h4 >> kind;
    @(posedge clk_sys);
    {lazy_activate, lazy_done, fp_instr} <= 3'h0;
  endtask : event_pulse
endmodule : fpcs_core_model

// *** tb.sv ***
`timescale 1ns/1ps
`include "fpcs_map.svh"
module tb;
  logic clk_sys, rst, cyc, stb, we, ack, acc_secure, ftns;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, fp_context_address;
  logic cur_secure, frame_alloc, bfa, mfa, hfa, thr, unp;
  logic lz_act, lz_done, fp_instr, pend_s, pend_ns, owner;
  logic [31:0] frame_fp_addr;
  int mismatches, n_compared;

  fpcs_core_model i_fpcs_core_model (.clk_sys(clk_sys),
    .cur_secure(cur_secure), .frame_alloc(frame_alloc),
    .bus_fault_able(bfa), .memory_fault_able(mfa), .hard_fault_able(hfa),
    .thread_mode(thr), .unprivileged(unp), .frame_fp_addr(frame_fp_addr),
    .lazy_activate(lz_act), .lazy_done(lz_done), .fp_instr(fp_instr));

  fpcs_regs i_fpcs_regs (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .acc_secure(acc_secure), .faults_to_nonsecure(ftns),
    .cur_secure(cur_secure), .frame_alloc(frame_alloc),
    .bus_fault_able(bfa), .memory_fault_able(mfa), .hard_fault_able(hfa),
    .thread_mode(thr), .unprivileged(unp), .frame_fp_addr(frame_fp_addr),
    .lazy_activate(lz_act), .lazy_done(lz_done), .fp_instr(fp_instr),
    .lazy_save_pending_s(pend_s), .lazy_save_pending_ns(pend_ns),
    .fp_owner_secure(owner), .fp_context_address(fp_context_address));

  // 50 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    wdat <= d;
    sel <= (a == `FPCS_CTRL_OFS) ? 4'h1 : 4'hf;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    r = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  // access security state and fault routing
  task automatic mode(input logic acc, input logic ft);
    @(posedge clk_sys);
    acc_secure <= acc;
    ftns <= ft;
  endtask : mode

  // status flags towards the core, sampled mid-cycle
  task automatic flags(input logic [2:0] exp);
    @(negedge clk_sys);
    check({29'h0, owner, pend_s, pend_ns}, {29'h0, exp});
  endtask : flags

  // watchdog
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    summarize;
  end

  initial begin
    {cyc, stb, we, acc_secure, ftns} = 5'h0;
    adr = 4'h0;
    wdat = 32'h0;
    sel = 4'h0;
    rst = 1'b1;
    mismatches = 0;
    n_compared = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    mode(1'b1, 1'b0);
    rd(`FPCS_CTRL_OFS, 32'h0);
    rd(`FPCS_ADDR_OFS, 32'h0);
    i_fpcs_core_model.alloc(1'b1, 5'h1f, 32'h2000_1237);
    i_fpcs_core_model.alloc(1'b0, 5'h1c, 32'h1000_00ff);
    rd(`FPCS_CTRL_OFS, 32'h7a);
    rd(`FPCS_ADDR_OFS, 32'h2000_1230);
    mode(1'b0, 1'b0);
    rd(`FPCS_CTRL_OFS, 32'h20);
    rd(`FPCS_ADDR_OFS, 32'h1000_00f8);
    mode(1'b0, 1'b1);
    rd(`FPCS_CTRL_OFS, 32'h70);
    check(fp_context_address, 32'h1000_00f8);
    i_fpcs_core_model.event_pulse(1'b1, 2'd0);
    flags(3'b110);
    check(fp_context_address, 32'h2000_1230);
    mode(1'b1, 1'b0);
    rd(`FPCS_CTRL_OFS, 32'h7f);
    i_fpcs_core_model.event_pulse(1'b1, 2'd1);
    i_fpcs_core_model.event_pulse(1'b0, 2'd2);
    flags(3'b000);
    wr(`FPCS_CTRL_OFS, 32'h0);
    rd(`FPCS_CTRL_OFS, 32'h0);
    mode(1'b0, 1'b0);
    wr(`FPCS_CTRL_OFS, 32'h7f);
    rd(`FPCS_CTRL_OFS, 32'h2b);
    flags(3'b001);
    mode(1'b1, 1'b0);
    rd(`FPCS_CTRL_OFS, 32'h0);
    mode(1'b0, 1'b1);
    rd(`FPCS_CTRL_OFS, 32'h2b);
    mode(1'b1, 1'b0);
    wr(`FPCS_ADDR_OFS, 32'hdead_beef);
    rd(`FPCS_ADDR_OFS, 32'hdead_bee8);
    wr(4'h8, 32'hffff_ffff);
    rd(4'h8, 32'h0);
    rd(`FPCS_ADDR_OFS, 32'hdead_bee8);
    mode(1'b0, 1'b0);
    rd(`FPCS_ADDR_OFS, 32'h1000_00f8);
    summarize;
  end
endmodule : tb
